// ==== verification/ccs_camera_capture_assertions.sv ====
// Port checks on the capture block, bound into every instance.
// Assumes one clock domain and the register map header.
`include "ccs_capture_regs.vh"
module ccs_capture_chk (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Register port
  input wire [`CCS_ADDR_W-1:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  // Flags and outputs
  input wire codec_fifo_full_in,
  input wire preview_fifo_full_in,
  input wire codec_wr_out,
  input wire preview_wr_out,
  input wire [10:0] preview_height_out,
  input wire [10:0] preview_width_out,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  wire rd_st = reg_rd_in && reg_addr_in == `CCS_OFS_STATUS;
  wire rd_im = reg_rd_in && reg_addr_in == `CCS_OFS_IMASK;
  wire wr_ps = reg_wr_in && reg_addr_in == `CCS_OFS_PSIZE;
  wire clr_all = reg_wr_in && reg_addr_in == `CCS_OFS_IEN_CLR && reg_wdata_in[9:0] == 10'h3FF;
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0) // idle read
    else $error("read data outside its cycle");
  status_rsvd_a: assert property (rd_st |=> reg_rdata_out[31:10] == 22'h0) // reserved bits
    else $error("status reserved bits set");
  mask_rsvd_a: assert property (rd_im |=> reg_rdata_out[31:10] == 22'h0 && !reg_rdata_out[3]) // no bit3
    else $error("mask view shows a missing source");
  height_map_a: assert property ( // plus one
    wr_ps && reg_wdata_in[9:0] < 10'h1E0 |-> ##2 preview_height_out == {1'b0, $past(reg_wdata_in[9:0], 2)} + 11'h001)
    else $error("preview height wrong");
  width_map_a: assert property ( // plus one
    wr_ps && reg_wdata_in[25:16] < 10'h280 |-> ##2 preview_width_out == {1'b0, $past(reg_wdata_in[25:16], 2)} + 11'h001)
    else $error("preview width wrong");
  size_max_a: assert property (preview_height_out <= `CCS_PREV_H_MAX && preview_width_out <= `CCS_PREV_W_MAX) // max
    else $error("preview size above limit");
  codec_full_a: assert property (codec_fifo_full_in [*8] |-> !codec_wr_out) // full refused
    else $error("codec write while full");
  prev_full_a: assert property (preview_fifo_full_in [*8] |-> !preview_wr_out) // full refused
    else $error("preview write while full");
  irq_off_a: assert property (clr_all |=> !irq_out) // all disabled
    else $error("interrupt with all sources off");
  cover property (preview_wr_out);
  cover property (codec_wr_out);
  cover property (irq_out);
endmodule // ccs_capture_chk
bind ccs_camera_capture ccs_capture_chk i_chk (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .codec_fifo_full_in, .preview_fifo_full_in, .codec_wr_out, .preview_wr_out,
  .preview_height_out, .preview_width_out, .irq_out);

// ==== verification/ccs_camera_capture_tb_top.sv ====
// Self-checking bench for the capture block with a sensor stand-in.
// Assumes the register map header; FIFO flags are driven here as the DMA side would.
`include "ccs_capture_regs.vh"
module ccs_camera_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ST = `CCS_OFS_STATUS;
  localparam logic [7:0] IM = `CCS_OFS_IMASK;
  localparam logic [7:0] CT = `CCS_OFS_CTRL;
  logic ref_clk_in, rst_in, reg_wr_in, reg_rd_in, sync_error_in;
  logic codec_fifo_full_in, preview_fifo_full_in, codec_fifo_empty_in, preview_fifo_empty_in;
  logic [7:0] reg_addr_in, sensor_data_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, d;
  logic sensor_pck_in, sensor_vsync_in, sensor_hsync_in, codec_wr_out, preview_wr_out, irq_out;
  logic [23:0] pixel_out;
  logic [10:0] preview_height_out, preview_width_out;
  int bad_count, num_checks, hits;
  ccs_camera_capture i_dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .sensor_pck_in, .sensor_vsync_in, .sensor_hsync_in, .sensor_data_in, .sync_error_in,
    .codec_fifo_full_in, .preview_fifo_full_in, .codec_fifo_empty_in, .preview_fifo_empty_in,
    .pixel_out, .codec_wr_out, .preview_wr_out, .preview_height_out, .preview_width_out, .irq_out);
  ccs_sensor_model i_sen (.pck_out(sensor_pck_in), .vsync_out(sensor_vsync_in), .hsync_out(sensor_hsync_in),
    .data_out(sensor_data_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    chk(reg_rdata_out & m, e);
  endtask
  task automatic frame(input logic [23:0] px, input int n);
    hits = 0;
    fork
      i_sen.frame(px, n);
      repeat (125) @(posedge ref_clk_in) if (preview_wr_out | codec_wr_out) begin
        hits++;
        d = {8'h00, pixel_out};
      end
    join
  endtask
  // Expected pixel for format m: bit 2 picks 565, bits 1:0 the byte order.
  function automatic logic [23:0] px_exp(input logic [2:0] m);
    logic [15:0] w;
    w = m[1] ? 16'hC3A5 : 16'hA5C3;
    if (m[1] ^ m[0]) w = {w[4:0], w[10:5], w[15:11]};
    if (m[2]) return {8'h00, w};
    return m[1:0] == 2'b00 ? 24'hA5C33C : 24'h3CC3A5;
  endfunction
  task automatic t_reset();
    rd(ST, 32'h00000182); // reset status
    rd(IM, 32'h00000004); // inverted bit
    rd(`CCS_OFS_PSIZE, 32'h0); // reset size
    rd(8'h18, 32'h0); // unmapped read
    chk({preview_width_out, preview_height_out}, {11'h001, 11'h001}); // field zero
    $display("test reset done");
  endtask
  task automatic t_psize();
    wr(`CCS_OFS_PSIZE, 32'hFFFFFFFF);
    rd(`CCS_OFS_PSIZE, `CCS_PS_MASK); // reserved zero
    chk({preview_width_out, preview_height_out}, {11'h280, 11'h1E0}); // clamped
    wr(`CCS_OFS_PSIZE, 32'h00310063);
    rd(`CCS_OFS_PSIZE, 32'h00310063); // readback
    chk({preview_width_out, preview_height_out}, {11'h032, 11'h064}); // plus one
    $display("test size done");
  endtask
  task automatic t_irq();
    wr(`CCS_OFS_IEN_SET, 32'hFFFFFFFF);
    rd(IM, 32'h000003F3); // all set
    chk(irq_out, 1'b1); // drained flags
    wr(`CCS_OFS_IEN_CLR, 32'h1);
    wr(`CCS_OFS_IEN_SET, 32'h0);
    wr(`CCS_OFS_IEN_CLR, 32'h0);
    rd(IM, 32'h000003F2); // zero no effect
    wr(`CCS_OFS_IEN_CLR, 32'h3FF);
    rd(IM, 32'h00000004); // all off
    chk(irq_out, 1'b0); // no source
    wr(CT, 32'h3);
    repeat (8) @(posedge ref_clk_in);
    rd(ST, 32'h00000186); // reset done
    wr(`CCS_OFS_IEN_SET, 32'h4);
    rd(IM, 32'h0); // enabled reads zero
    chk(irq_out, 1'b1); // reset done source
    wr(`CCS_OFS_IEN_CLR, 32'h4);
    $display("test interrupt done");
  endtask
  task automatic t_pixels();
    wr(CT, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(`CCS_OFS_FORMAT, {m[1:0], 17'h0, m[2], 12'h0});
      frame(24'hA5C33C, m[2] ? 2 : 3);
      chk(hits, 1); // one pixel
      chk(d, {8'h00, px_exp(m[2:0])}); // byte order
    end
    rd(ST, 32'h00000185); // frame start
    $display("test pixel done");
  endtask
  task automatic t_fault();
    @(posedge ref_clk_in);
    preview_fifo_empty_in <= 1'b0;
    frame(24'h112233, 3);
    chk(hits, 0); // frame skipped
    rd(ST, 32'h00000300, 32'h00000380); // overrun flag
    preview_fifo_empty_in <= 1'b1;
    preview_fifo_full_in <= 1'b1;
    frame(24'h112233, 3);
    chk(hits, 0); // full refused
    rd(ST, 32'h40, 32'h40); // overflow flag
    preview_fifo_full_in <= 1'b0;
    wr(CT, 32'h8000);
    rd(ST, 32'h8, 32'h8); // codec pending
    // The empty flag stays high at frame start, so the codec frame is not skipped as a flush.
    codec_fifo_full_in <= 1'b1;
    frame(24'h445566, 3);
    rd(ST, 32'h120, 32'h128); // codec path
    codec_fifo_empty_in <= 1'b0;
    rd(ST, 32'h0, 32'h100); // codec not drained
    codec_fifo_full_in <= 1'b0;
    codec_fifo_empty_in <= 1'b1;
    wr(CT, 32'hC0);
    sync_error_in <= 1'b1;
    @(posedge ref_clk_in);
    sync_error_in <= 1'b0;
    rd(ST, 32'h10, 32'h10); // sync error
    fork
      i_sen.frame(24'h778899, 3);
      begin
        repeat (20) @(posedge ref_clk_in);
        wr(CT, 32'h2);
        rd(ST, 32'h0, 32'h2); // frame still running
      end
    join
    rd(ST, 32'h2, 32'h2); // shut down
    frame(24'h778899, 3);
    chk(hits, 0); // no capture
    $display("test fault done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end
  initial begin
    rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, sync_error_in, codec_fifo_full_in, preview_fifo_full_in} = 5'h0;
    {codec_fifo_empty_in, preview_fifo_empty_in} = 2'h3;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_psize();
    t_irq();
    t_pixels();
    t_fault();
    print_verdict();
  end
endmodule // ccs_camera_capture_tb_top

// ==== verification/ccs_sensor_model.sv ====
// Image sensor stand-in: syncs, data and a pixel clock that runs only in frames.
// Assumes the capture block samples these pins on its own clock.
module ccs_sensor_model (
  // Sensor pins
  output logic pck_out,
  output logic vsync_out,
  output logic hsync_out,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {pck_out, vsync_out, hsync_out} = 3'h0;
    data_out = 8'h00;
  end
  // One frame of one line, first byte from the top of px.
  task automatic frame(input logic [23:0] px, input int n);
    vsync_out <= 1'b1;
    #200;
    hsync_out <= 1'b1;
    for (int i = 0; i < n; i++) begin
      data_out <= px[23 - 8 * i -: 8];
      #40 pck_out <= 1'b1;
      #40 pck_out <= 1'b0;
    end
    hsync_out <= 1'b0;
    // Released lanes show the inverse, so a stale byte never passes for fresh data.
    data_out <= ~data_out;
    #80 vsync_out <= 1'b0;
    #400;
  endtask
endmodule // ccs_sensor_model

// ==== verilog/ccs_camera_capture.v ====
// Status, interrupt control, preview size and pixel byte packing of the camera capture unit.
// Assumes FIFO flags and the embedded sync decoder run on ref_clk_in; sensor pins are asynchronous.
// Contract
// R1 - 565 byte order picks one of four layouts
// R2 - 888 order zero is RGB, else BGR
// R3 - Status bit 0 flags frame start
// R4 - Disabled stops capture, FIFOs stay readable
// R5 - Bit 2 set when software reset completes
// R6 - Bit 3 codec pending until next frame
// R7 - Sync error sets bit 4, frame dropped
// R8 - Codec write while full sets bit 5
// R9 - Preview write while full sets bit 6
// R10 - Bit 7 shows preview FIFO drained
// R11 - Bit 8 shows codec FIFO drained
// R12 - Vsync during flush skips frame, bit 9
// R13 - Enable register sets sources, bit 3 none
// R14 - Disable register clears sources
// R15 - Mask view shows enabled sources
// R16 - Reset-done mask bit reads inverted
// R17 - Preview height is field plus one, 480 max
// R18 - Preview width bits 25:16 plus one, 640 max
// R19 - Control reset bit restarts capture interface
// R20 - Shutdown waits for current frame end
// R21 - Codec enable write raises codec pending
// R22 - Interrupt when enabled flag is set
// R23 - Reset clears flags; reserved bits zero
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "ccs_capture_regs.vh"

module ccs_camera_capture (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Register port
  input wire [`CCS_ADDR_W-1:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Sensor pins
  input wire sensor_pck_in,
  input wire sensor_vsync_in,
  input wire sensor_hsync_in,
  input wire [7:0] sensor_data_in,
  // Datapath flags
  input wire sync_error_in,
  input wire codec_fifo_full_in,
  input wire preview_fifo_full_in,
  input wire codec_fifo_empty_in,
  input wire preview_fifo_empty_in,
  // Pixel output
  output reg [23:0] pixel_out,
  output reg codec_wr_out,
  output reg preview_wr_out,
  // Preview size and interrupt
  output reg [10:0] preview_height_out,
  output reg [10:0] preview_width_out,
  output wire irq_out
);

  localparam ST_RESET = 2'h0;
  localparam ST_OFF = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam integer SWRST_CYC_I = `CCS_SWRST_CYC;
  localparam [3:0] SWRST_CYC = SWRST_CYC_I[3:0];

  reg [31:0] ctrl_q;
  reg [31:0] format_q;
  reg [31:0] psize_q;
  reg [`CCS_ST_W-1:0] status_q;
  reg [`CCS_ST_W-1:0] ien_q;
  reg [`CCS_ST_W-1:0] ien_d;
  reg [1:0] state_q;
  reg [3:0] rst_cnt_q;
  reg in_frame_q;
  reg discard_q;
  reg codec_act_q;
  reg [1:0] byte_cnt_q;
  reg [7:0] byte0_q;
  reg [7:0] byte1_q;
  reg [2:0] pck_m_q;
  reg [1:0] vs_m_q;
  reg [1:0] hs_m_q;
  reg [7:0] d_m0_q;
  reg [7:0] d_m1_q;
  reg vs_prev_q;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == `CCS_OFS_CTRL);
  wire wr_rst = wr_ctrl && reg_wdata_in[`CCS_CTRL_RST_BIT];
  wire wr_codec = wr_ctrl && reg_wdata_in[`CCS_CTRL_CODEC_BIT];
  wire wr_fmt = reg_wr_in && (reg_addr_in == `CCS_OFS_FORMAT);
  wire wr_psize = reg_wr_in && (reg_addr_in == `CCS_OFS_PSIZE);
  wire rd_status = reg_rd_in && (reg_addr_in == `CCS_OFS_STATUS);
  wire mode565 = format_q[`CCS_FMT_WIDTH_BIT];
  wire [1:0] order = format_q[`CCS_FMT_ORDER_HI:`CCS_FMT_ORDER_LO];
  wire pck_rise = pck_m_q[1] && !pck_m_q[2];
  wire pck_fall = !pck_m_q[1] && pck_m_q[2];
  wire sample = ctrl_q[`CCS_CTRL_PCKPOL_BIT] ? pck_fall : pck_rise;
  wire vs_s = vs_m_q[1];
  wire frame_start = vs_s && !vs_prev_q && (state_q != ST_RESET);
  wire flushing = !codec_fifo_empty_in || !preview_fifo_empty_in;
  wire last_byte = mode565 ? (byte_cnt_q == 2'h1) : (byte_cnt_q == 2'h2);
  wire take = sample && hs_m_q[1] && in_frame_q && !discard_q && (state_q == ST_RUN);
  wire [7:0] d_s = d_m1_q;
  wire crc_drop = sync_error_in && ctrl_q[`CCS_CTRL_EMB_BIT] && ctrl_q[`CCS_CTRL_CRC_BIT];
  // A frame that starts while the interface is off must not consume a codec request.
  wire codec_grab = frame_start && status_q[`CCS_ST_CPEND] && !flushing && (state_q == ST_RUN);
  // R1 565 words, high half first or second, and red/blue swapped.
  wire [15:0] w565_hi_first = {byte0_q, d_s};
  wire [15:0] w565_lo_first = {d_s, byte0_q};
  wire [15:0] w565_hi_swap = {w565_hi_first[4:0], w565_hi_first[10:5], w565_hi_first[15:11]};
  wire [15:0] w565_lo_swap = {w565_lo_first[4:0], w565_lo_first[10:5], w565_lo_first[15:11]};

  // Synchronisers on the sensor pins; only the second stage feeds logic.
  // The pixel clock has a third stage so that its edges are found from settled values only.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pck_m_q <= 3'h0;
      vs_m_q <= 2'h0;
      hs_m_q <= 2'h0;
      d_m0_q <= 8'h00;
      d_m1_q <= 8'h00;
      vs_prev_q <= 1'b0;
    end else begin
      pck_m_q <= {pck_m_q[1:0], sensor_pck_in};
      vs_m_q <= {vs_m_q[0], sensor_vsync_in};
      hs_m_q <= {hs_m_q[0], sensor_hsync_in};
      d_m0_q <= sensor_data_in;
      d_m1_q <= d_m0_q;
      vs_prev_q <= vs_s;
    end
  end

  // Software-visible configuration registers.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `CCS_CTRL_RESET;
      format_q <= 32'h00000000;
      psize_q <= 32'h00000000;
      ien_q <= {`CCS_ST_W{1'b0}};
    end else begin
      // R23 reserved bits ignore writes
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_in & `CCS_CTRL_MASK;
      end
      if (wr_fmt) begin
        format_q <= reg_wdata_in & `CCS_FMT_MASK;
      end
      if (wr_psize) begin
        psize_q <= reg_wdata_in & `CCS_PS_MASK;
      end
      ien_q <= ien_d;
    end
  end

  // Enable set and clear; a source written with zero keeps its state.
  always @* begin
    ien_d = ien_q;
    // R13 set sources
    if (reg_wr_in && (reg_addr_in == `CCS_OFS_IEN_SET)) begin
      ien_d = (ien_q | reg_wdata_in[`CCS_ST_W-1:0]) & `CCS_IRQ_SRC;
    end
    // R14 clear sources
    if (reg_wr_in && (reg_addr_in == `CCS_OFS_IEN_CLR)) begin
      ien_d = ien_q & ~reg_wdata_in[`CCS_ST_W-1:0];
    end
  end

  // Capture state: software reset, enabled running, or shut down.
  // A software reset lasts a fixed count and leaves the interface off until shutdown is cleared.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_OFF;
      rst_cnt_q <= 4'h0;
      in_frame_q <= 1'b0;
      discard_q <= 1'b0;
      codec_act_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RESET: begin
          // R19 reset sequence
          if (rst_cnt_q == 4'h1) begin
            state_q <= ST_OFF;
          end
          rst_cnt_q <= rst_cnt_q - 4'h1;
          in_frame_q <= 1'b0;
          discard_q <= 1'b0;
          codec_act_q <= 1'b0;
        end
        default: begin
          if (frame_start) begin
            in_frame_q <= 1'b1;
            // R12 skip on flush
            discard_q <= flushing;
            // R6 codec frame begins
            codec_act_q <= codec_grab;
          end else if (!vs_s) begin
            in_frame_q <= 1'b0;
            codec_act_q <= 1'b0;
          end
          // R7 drop frame
          if (crc_drop) begin
            discard_q <= 1'b1;
          end
          // R20 shutdown after frame
          if (ctrl_q[`CCS_CTRL_SHUT_BIT] && !in_frame_q) begin
            state_q <= ST_OFF;
          end else if (!ctrl_q[`CCS_CTRL_SHUT_BIT] && (state_q == ST_OFF) && !vs_s) begin
            state_q <= ST_RUN;
          end
        end
      endcase
      if (wr_rst) begin
        state_q <= ST_RESET;
        rst_cnt_q <= SWRST_CYC;
      end
    end
  end

  // Byte gathering and pixel reordering.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      byte_cnt_q <= 2'h0;
      byte0_q <= 8'h00;
      byte1_q <= 8'h00;
      pixel_out <= 24'h000000;
      codec_wr_out <= 1'b0;
      preview_wr_out <= 1'b0;
    end else begin
      codec_wr_out <= 1'b0;
      preview_wr_out <= 1'b0;
      if (!hs_m_q[1] || frame_start || (state_q != ST_RUN)) begin
        byte_cnt_q <= 2'h0;
      end else if (take) begin
        if (byte_cnt_q == 2'h0) begin
          byte0_q <= d_s;
        end
        if (byte_cnt_q == 2'h1) begin
          byte1_q <= d_s;
        end
        if (last_byte) begin
          byte_cnt_q <= 2'h0;
          if (mode565) begin
            // R1 four layouts
            case (order)
              2'h0: pixel_out <= {8'h00, w565_hi_first};
              2'h1: pixel_out <= {8'h00, w565_hi_swap};
              2'h2: pixel_out <= {8'h00, w565_lo_swap};
              default: pixel_out <= {8'h00, w565_lo_first};
            endcase
          end else if (order == 2'h0) begin
            // R2 component sequence
            pixel_out <= {byte0_q, byte1_q, d_s};
          end else begin
            pixel_out <= {d_s, byte1_q, byte0_q};
          end
          // R4 capture only when on
          preview_wr_out <= !preview_fifo_full_in;
          codec_wr_out <= codec_act_q && !codec_fifo_full_in;
        end else begin
          byte_cnt_q <= byte_cnt_q + 2'h1;
        end
      end
    end
  end

  // Status flags; events win over the clear-on-read.
  // Bits 1, 7 and 8 are copied every cycle and so lag their sources by one cycle.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= {`CCS_ST_W{1'b0}};
    end else begin
      if (rd_status) begin
        status_q[`CCS_ST_SOF] <= 1'b0;
        status_q[`CCS_ST_CRC] <= 1'b0;
        status_q[`CCS_ST_COVF] <= 1'b0;
        status_q[`CCS_ST_POVF] <= 1'b0;
        status_q[`CCS_ST_FOVR] <= 1'b0;
      end
      // R3 frame start
      if (frame_start) begin
        status_q[`CCS_ST_SOF] <= 1'b1;
      end
      // R4 disabled level
      status_q[`CCS_ST_SHUT] <= (state_q == ST_OFF);
      // R5 reset done
      if (wr_rst) begin
        status_q[`CCS_ST_RSTDONE] <= 1'b0;
      end else if ((state_q == ST_RESET) && (rst_cnt_q == 4'h1)) begin
        status_q[`CCS_ST_RSTDONE] <= 1'b1;
      end
      // R21 codec request
      if (wr_codec) begin
        status_q[`CCS_ST_CPEND] <= 1'b1;
      end else if (codec_grab) begin
        status_q[`CCS_ST_CPEND] <= 1'b0;
      end
      // R7 sync error
      if (crc_drop) begin
        status_q[`CCS_ST_CRC] <= 1'b1;
      end
      // R8 codec overrun
      if (take && last_byte && codec_act_q && codec_fifo_full_in) begin
        status_q[`CCS_ST_COVF] <= 1'b1;
      end
      // R9 preview overrun
      if (take && last_byte && preview_fifo_full_in) begin
        status_q[`CCS_ST_POVF] <= 1'b1;
      end
      // R10 preview drained
      status_q[`CCS_ST_PEMP] <= preview_fifo_empty_in;
      // R11 codec drained
      status_q[`CCS_ST_CEMP] <= codec_fifo_empty_in;
      // R12 frame overrun
      if (frame_start && flushing) begin
        status_q[`CCS_ST_FOVR] <= 1'b1;
      end
    end
  end

  // The level is built from flops only, so bus activity cannot make it glitch.
  // R22 enabled flags raise interrupt
  assign irq_out = |(status_q & ien_q & `CCS_IRQ_SRC);

  // Preview size outputs, limited to the largest supported frame.
  // Clamping rather than wrapping keeps an oversize field from giving a tiny frame.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      preview_height_out <= 11'h001;
      preview_width_out <= 11'h001;
    end else begin
      // R17 height plus one
      if ({1'b0, psize_q[`CCS_PS_V_HI:`CCS_PS_V_LO]} >= `CCS_PREV_H_MAX) begin
        preview_height_out <= `CCS_PREV_H_MAX;
      end else begin
        preview_height_out <= {1'b0, psize_q[`CCS_PS_V_HI:`CCS_PS_V_LO]} + 11'h001;
      end
      // R18 width plus one
      if ({1'b0, psize_q[`CCS_PS_H_HI:`CCS_PS_H_LO]} >= `CCS_PREV_W_MAX) begin
        preview_width_out <= `CCS_PREV_W_MAX;
      end else begin
        preview_width_out <= {1'b0, psize_q[`CCS_PS_H_HI:`CCS_PS_H_LO]} + 11'h001;
      end
    end
  end

  // Read port; write-only control bits and unmapped words read zero.
  // The status clear-on-read happens on the same edge that loads the read data.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_addr_in == `CCS_OFS_CTRL) begin
      reg_rdata_out <= ctrl_q & ~(32'h00000001 | 32'h00008000);
    end else if (reg_addr_in == `CCS_OFS_FORMAT) begin
      reg_rdata_out <= format_q;
    end else if (reg_addr_in == `CCS_OFS_STATUS) begin
      // R23 reserved read zero
      reg_rdata_out <= {22'h000000, status_q};
    end else if (reg_addr_in == `CCS_OFS_IMASK) begin
      // R15 R16 mask view
      reg_rdata_out <= {22'h000000, (ien_q ^ `CCS_IMASK_INV) & `CCS_IRQ_SRC};
    end else if (reg_addr_in == `CCS_OFS_PSIZE) begin
      reg_rdata_out <= psize_q;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

endmodule // ccs_camera_capture

// ==== verilog/ccs_capture_regs.vh ====
// Register map, field positions, reset values and timing counts of the capture status block.
// Assumes a byte-addressed register port with one aligned 32-bit word per register.
`ifndef CCS_CAPTURE_REGS_VH
`define CCS_CAPTURE_REGS_VH

`define CCS_ADDR_W 8
`define CCS_OFS_CTRL 8'h00
`define CCS_OFS_FORMAT 8'h04
`define CCS_OFS_STATUS 8'h08
`define CCS_OFS_IEN_SET 8'h0C
`define CCS_OFS_IEN_CLR 8'h10
`define CCS_OFS_IMASK 8'h14
`define CCS_OFS_PSIZE 8'h20

`define CCS_CTRL_RST_BIT 0
`define CCS_CTRL_SHUT_BIT 1
`define CCS_CTRL_PCKPOL_BIT 4
`define CCS_CTRL_EMB_BIT 6
`define CCS_CTRL_CRC_BIT 7
`define CCS_CTRL_CODEC_BIT 15
`define CCS_CTRL_RESET 32'h00000002
`define CCS_CTRL_MASK 32'hFFFFF7DF

`define CCS_FMT_WIDTH_BIT 12
`define CCS_FMT_ORDER_HI 31
`define CCS_FMT_ORDER_LO 30
`define CCS_FMT_MASK 32'hF7FFFFFF

`define CCS_ST_SOF 0
`define CCS_ST_SHUT 1
`define CCS_ST_RSTDONE 2
`define CCS_ST_CPEND 3
`define CCS_ST_CRC 4
`define CCS_ST_COVF 5
`define CCS_ST_POVF 6
`define CCS_ST_PEMP 7
`define CCS_ST_CEMP 8
`define CCS_ST_FOVR 9
`define CCS_ST_W 10
`define CCS_IRQ_SRC 10'h3F7
`define CCS_IMASK_INV 10'h004

`define CCS_PS_V_LO 0
`define CCS_PS_V_HI 9
`define CCS_PS_H_LO 16
`define CCS_PS_H_HI 25
`define CCS_PS_MASK 32'h03FF03FF
`define CCS_PREV_H_MAX 11'h1E0
`define CCS_PREV_W_MAX 11'h280

`define CCS_CLK_NS 8
`define CCS_SWRST_NS 32
`define CCS_SWRST_CYC ((`CCS_SWRST_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)

`endif
